// ---- common/cca_pkg.sv ----
// Purpose: Shared constants for the counter array output-mode block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   Register indices are multiplied by four for byte addresses
package cca_pkg;
    // ==========================================================
    // Register indices and byte address width
    localparam logic [7:0] IDX_CTRL = 8'hd8;
    localparam logic [7:0] IDX_MODE = 8'hda;
    localparam logic [7:0] IDX_CNT_LO = 8'hf9;
    localparam logic [7:0] IDX_CNT_HI = 8'hfa;
    localparam logic [7:0] IDX_CMP_LO = 8'hfb;
    localparam logic [7:0] IDX_CMP_HI = 8'hfc;
    localparam int ADDR_W = 12;
    // ==========================================================
    // Mode register field positions
    localparam int MODE_WIDE = 7;
    localparam int MODE_MATCH = 3;
    localparam int MODE_TOG = 2;
    localparam int MODE_PULSE = 1;
    localparam int MODE_IE = 0;
    localparam logic [7:0] MODE_MASK = 8'h8f;
    // ==========================================================
    // Control register field positions
    localparam int CTRL_RUN = 6;
    localparam int CTRL_PIN = 1;
    localparam int CTRL_FLAG = 0;
    // ==========================================================
    // Reset values and responses
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Output pin operating modes
    typedef enum logic [1:0] {
        CCA_IDLE, CCA_TOGGLE, CCA_PULSE, CCA_FREQ
    } cca_mode_t;
endpackage

// ---- hdl/cca_chan.sv ----
// Purpose: One capture/compare module driving its output pin
// Assumes: Counter and compare value come from the same clock domain
// Notes:   Mode is decoded from toggle and pulse enables each cycle
`timescale 1ns/1ns
`default_nettype none
module cca_chan (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Configuration
    input wire logic match_toggle_enable,
    input wire logic pulse_mode_enable,
    input wire logic wide_pulse_select,
    input wire logic [15:0] cnt,
    input wire logic [15:0] cmp,
    // Results
    output logic module_output_pin,
    output logic match_evt
);
    cca_pkg::cca_mode_t mode;
    logic pin_ff;
    logic [7:0] target_ff;
    logic lo_match;
    logic full_match;

    // Mode decode: both enables together select frequency output
    always_comb begin
        case ({match_toggle_enable, pulse_mode_enable})
            2'b10: mode = cca_pkg::CCA_TOGGLE;
            2'b01: mode = cca_pkg::CCA_PULSE;
            2'b11: mode = cca_pkg::CCA_FREQ;
            default: mode = cca_pkg::CCA_IDLE;
        endcase
    end

    assign full_match = (cnt == cmp);
    assign lo_match = (mode == cca_pkg::CCA_FREQ) ?
        (cnt[7:0] == target_ff) : (cnt[7:0] == cmp[7:0]);
    // Event source follows the width the mode works on
    assign match_evt = ((mode == cca_pkg::CCA_FREQ) ||
        (mode == cca_pkg::CCA_PULSE && !wide_pulse_select)) ?
        lo_match : full_match;
    assign module_output_pin = pin_ff;

    // ==========================================================
    // Frequency output: next edge point advances by the high byte
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            target_ff <= 8'h00;
        end else if (mode != cca_pkg::CCA_FREQ) begin
            target_ff <= cmp[7:0];
        end else if (lo_match) begin
            target_ff <= 8'(target_ff + cmp[15:8]);
        end
    end

    // ==========================================================
    // Output pin level per mode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_ff <= 1'b0;
        end else begin
            case (mode)
                cca_pkg::CCA_TOGGLE: begin
                    if (full_match) begin
                        pin_ff <= ~pin_ff;
                    end
                end
                cca_pkg::CCA_FREQ: begin
                    if (lo_match) begin
                        pin_ff <= ~pin_ff;
                    end
                end
                cca_pkg::CCA_PULSE: begin
                    if (wide_pulse_select) begin
                        pin_ff <= (cnt >= cmp);
                    end else begin
                        pin_ff <= (cnt[7:0] >= cmp[7:0]);
                    end
                end
                default: pin_ff <= pin_ff;
            endcase
        end
    end

    // ==========================================================
    // Checks
    a_toggle_on_match: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode == cca_pkg::CCA_TOGGLE && full_match) |=>
        (pin_ff != $past(pin_ff)))
        else $error("Toggle mode missed a match");
    a_freq_step: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode == cca_pkg::CCA_FREQ && lo_match) |=>
        (pin_ff != $past(pin_ff)) &&
        (target_ff == 8'($past(target_ff) + $past(cmp[15:8]))))
        else $error("Frequency output did not step");
    a_pwm8_level: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode == cca_pkg::CCA_PULSE && !wide_pulse_select) |=>
        (pin_ff == ($past(cnt[7:0]) >= $past(cmp[7:0]))))
        else $error("8-bit pulse level wrong");
    a_pwm16_level: assert property (@(posedge mclk) disable iff (sys_rst)
        (mode == cca_pkg::CCA_PULSE && wide_pulse_select) |=>
        (pin_ff == ($past(cnt) >= $past(cmp))))
        else $error("16-bit pulse level wrong");
endmodule
`default_nettype wire

// ---- hdl/cca_top.sv ----
// Purpose: Counter array module with output modes behind AXI4-Lite
// Assumes: One clock, synchronous active-high reset
// Notes:   One capture/compare module; byte address is index times four
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cca_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // AXI4-Lite write address
    input wire logic [cca_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [cca_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Module output and request
    output logic module_output_pin,
    output logic irq_req
);
    // Byte address of a register index
    function automatic logic [cca_pkg::ADDR_W-1:0] reg_addr(
        input logic [7:0] idx);
        reg_addr = {2'b00, idx, 2'b00};
    endfunction

    // True when the address names one of the registers
    function automatic logic mapped(input logic [cca_pkg::ADDR_W-1:0] a);
        mapped = (a == reg_addr(cca_pkg::IDX_CTRL)) ||
            (a == reg_addr(cca_pkg::IDX_MODE)) ||
            (a == reg_addr(cca_pkg::IDX_CNT_LO)) ||
            (a == reg_addr(cca_pkg::IDX_CNT_HI)) ||
            (a == reg_addr(cca_pkg::IDX_CMP_LO)) ||
            (a == reg_addr(cca_pkg::IDX_CMP_HI));
    endfunction

    logic [cca_pkg::ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [15:0] cnt_ff;
    logic [15:0] cmp_ff;
    logic [7:0] mode_ff;
    logic run_ff;
    logic flag_ff;
    logic match_evt;
    logic wr_do;
    logic wr_lo;
    logic rd_take;
    logic flag_set;
    logic flag_clr;

    // ==========================================================
    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_lo = wr_do && wstrb_ff[0];
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // Capture write address and data
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_got_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_do) begin
                w_got_ff <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= cca_pkg::RESP_OKAY;
        end else if (wr_do) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= mapped(awaddr_ff) ? cca_pkg::RESP_OKAY :
                cca_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mode_ff <= cca_pkg::MODE_RST;
            cmp_ff <= cca_pkg::CMP_RST;
            run_ff <= 1'b0;
        end else if (wr_lo) begin
            if (awaddr_ff == reg_addr(cca_pkg::IDX_MODE)) begin
                mode_ff <= wdata_ff[7:0] & cca_pkg::MODE_MASK;
            end
            if (awaddr_ff == reg_addr(cca_pkg::IDX_CMP_LO)) begin
                cmp_ff[7:0] <= wdata_ff[7:0];
            end
            if (awaddr_ff == reg_addr(cca_pkg::IDX_CMP_HI)) begin
                cmp_ff[15:8] <= wdata_ff[7:0];
            end
            if (awaddr_ff == reg_addr(cca_pkg::IDX_CTRL)) begin
                run_ff <= wdata_ff[cca_pkg::CTRL_RUN];
            end
        end
    end

    // ==========================================================
    // Counter: byte writes load, otherwise counts while running
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_ff <= cca_pkg::CNT_RST;
        end else if (wr_lo &&
            awaddr_ff == reg_addr(cca_pkg::IDX_CNT_LO)) begin
            cnt_ff[7:0] <= wdata_ff[7:0];
        end else if (wr_lo &&
            awaddr_ff == reg_addr(cca_pkg::IDX_CNT_HI)) begin
            cnt_ff[15:8] <= wdata_ff[7:0];
        end else if (run_ff) begin
            cnt_ff <= 16'(cnt_ff + 16'h0001);
        end
    end

    // ==========================================================
    // Event flag: set on enabled match, cleared by writing one
    assign flag_set = match_evt && mode_ff[cca_pkg::MODE_MATCH];
    assign flag_clr = wr_lo && awaddr_ff == reg_addr(cca_pkg::IDX_CTRL) &&
        wdata_ff[cca_pkg::CTRL_FLAG];
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flag_ff <= 1'b0;
        end else if (flag_set) begin
            flag_ff <= 1'b1; // Set wins over clear
        end else if (flag_clr) begin
            flag_ff <= 1'b0;
        end
    end
    assign irq_req = flag_ff && mode_ff[cca_pkg::MODE_IE];

    // ==========================================================
    // Read channel: data registered, one cycle after address
    assign s_axi_arready = !rvalid_ff;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= cca_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= mapped(s_axi_araddr) ? cca_pkg::RESP_OKAY :
                cca_pkg::RESP_SLVERR;
            rdata_ff <= 32'h0000_0000;
            case (s_axi_araddr)
                reg_addr(cca_pkg::IDX_CNT_LO):
                    rdata_ff[7:0] <= cnt_ff[7:0];
                reg_addr(cca_pkg::IDX_CNT_HI):
                    rdata_ff[7:0] <= cnt_ff[15:8];
                reg_addr(cca_pkg::IDX_CMP_LO): rdata_ff[7:0] <= cmp_ff[7:0];
                reg_addr(cca_pkg::IDX_CMP_HI): rdata_ff[7:0] <= cmp_ff[15:8];
                reg_addr(cca_pkg::IDX_MODE): rdata_ff[7:0] <= mode_ff;
                reg_addr(cca_pkg::IDX_CTRL): begin
                    rdata_ff[cca_pkg::CTRL_RUN] <= run_ff;
                    rdata_ff[cca_pkg::CTRL_PIN] <= module_output_pin;
                    rdata_ff[cca_pkg::CTRL_FLAG] <= flag_ff;
                end
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Capture/compare module
    cca_chan u_chan (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .match_toggle_enable(mode_ff[cca_pkg::MODE_TOG]),
        .pulse_mode_enable(mode_ff[cca_pkg::MODE_PULSE]),
        .wide_pulse_select(mode_ff[cca_pkg::MODE_WIDE]),
        .cnt(cnt_ff),
        .cmp(cmp_ff),
        .module_output_pin(module_output_pin),
        .match_evt(match_evt)
    );

    // ==========================================================
    // Checks
    sequence s_lo_write;
        wr_lo && awaddr_ff == reg_addr(cca_pkg::IDX_CNT_LO);
    endsequence
    sequence s_hi_read;
        rd_take && s_axi_araddr == reg_addr(cca_pkg::IDX_CNT_HI);
    endsequence
    a_irq_follows_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        (flag_set && mode_ff[cca_pkg::MODE_IE]) |=> irq_req)
        else $error("Enabled event raised no request");
    a_irq_masked: assert property (@(posedge mclk) disable iff (sys_rst)
        !mode_ff[cca_pkg::MODE_IE] |-> !irq_req)
        else $error("Request raised while disabled");
    a_low_byte_load: assert property (@(posedge mclk) disable iff (sys_rst)
        s_lo_write |=> cnt_ff[7:0] == $past(wdata_ff[7:0]))
        else $error("Low counter byte not loaded");
    a_high_byte_read: assert property (@(posedge mclk) disable iff (sys_rst)
        s_hi_read |=> s_axi_rvalid &&
        s_axi_rdata == {24'h000000, $past(cnt_ff[15:8])})
        else $error("High counter byte read wrong");
endmodule
`default_nettype wire

// ---- dv/cca_top_test.sv ----
// Purpose: Self-checking bench for the counter array output-mode block
// Assumes: AXI4-Lite register access, counter stopped unless a test runs it
// Notes:   Byte address is register index times four; one module only
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module cca_top_test;
    // =========================================================
    // Stimulus and observed signals
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, pin, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int checks = 0;
    int n_mismatch = 0;
    int gap;
    logic last;

    cca_top i_cca_top (.mclk(mclk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .module_output_pin(pin), .irq_req(irq));

    // =========================================================
    // Clock of 8 ns
    initial begin
        forever #4 mclk = ~mclk;
    end

    // Byte address of a register index
    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    // =========================================================
    // Bus tasks: ready sampled before the edge, released after it
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        logic aw_t, w_t, b_t;
        logic [1:0] r;
        int k;
        b_t = 1'b0;
        k = 0;
        r = 2'h3;
        @(posedge mclk);
        awaddr <= ad(idx);
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_t && k < 100) begin
            @(negedge mclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid && bready;
            r = bresp;
            @(posedge mclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) bready <= 1'b0;
            k++;
        end
        // Let the committed write reach the pin before anyone looks
        @(negedge mclk);
        `CHK(b_t, 1'b1)
        `CHK(r, er)
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ed,
                          input logic [1:0] er);
        logic r_t;
        logic [31:0] v;
        logic [1:0] r;
        int k;
        r_t = 1'b0;
        k = 0;
        v = 32'hffff_ffff;
        r = 2'h3;
        @(posedge mclk);
        araddr <= ad(idx);
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_t && k < 100) begin
            @(negedge mclk);
            if (arvalid && arready) begin
                @(posedge mclk);
                arvalid <= 1'b0;
                @(negedge mclk);
            end
            r_t = rvalid && rready;
            v = rdata;
            r = rresp;
            @(posedge mclk);
            if (r_t) rready <= 1'b0;
            k++;
        end
        `CHK(r_t, 1'b1)
        `CHK(v, {24'h00_0000, ed})
        `CHK(r, er)
    endtask

    // Cycles between two changes of the output pin
    task automatic pin_gap(output int g);
        int k;
        k = 0;
        @(negedge mclk);
        last = pin;
        while (pin === last && k < 300) begin
            @(negedge mclk);
            k++;
        end
        last = pin;
        g = 0;
        while (pin === last && g < 300) begin
            @(negedge mclk);
            g++;
        end
    endtask

    // =========================================================
    // Closing and watchdog
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        conclude();
    end

    // =========================================================
    // Test sequence
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        // Counter bytes: reset, read back, unmapped place
        rd_chk(cca_pkg::IDX_CNT_LO, 8'h00, cca_pkg::RESP_OKAY);
        rd_chk(cca_pkg::IDX_CNT_HI, 8'h00, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CNT_LO, 8'ha5, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CNT_HI, 8'h3c, cca_pkg::RESP_OKAY);
        rd_chk(cca_pkg::IDX_CNT_LO, 8'ha5, cca_pkg::RESP_OKAY);
        rd_chk(cca_pkg::IDX_CNT_HI, 8'h3c, cca_pkg::RESP_OKAY);
        wr(8'h00, 8'h5a, cca_pkg::RESP_SLVERR);
        rd_chk(8'h00, 8'h00, cca_pkg::RESP_SLVERR);
        $display("test counter bytes done");

        // Match toggle once, flag and gated request
        wr(cca_pkg::IDX_CNT_LO, 8'h00, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CNT_HI, 8'h00, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CMP_LO, 8'h20, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CMP_HI, 8'h00, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_MODE, 8'h0c, cca_pkg::RESP_OKAY);
        `CHK(pin, 1'b0)
        wr(cca_pkg::IDX_CTRL, 8'h40, cca_pkg::RESP_OKAY);
        repeat (60) @(negedge mclk);
        `CHK(pin, 1'b1)
        `CHK(irq, 1'b0)
        rd_chk(cca_pkg::IDX_CTRL, 8'h43, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CTRL, 8'h00, cca_pkg::RESP_OKAY);
        `CHK(pin, 1'b1)
        wr(cca_pkg::IDX_MODE, 8'h0d, cca_pkg::RESP_OKAY);
        `CHK(irq, 1'b1)
        wr(cca_pkg::IDX_CTRL, 8'h01, cca_pkg::RESP_OKAY);
        repeat (2) @(negedge mclk);
        `CHK(irq, 1'b0)
        $display("test toggle and request done");

        // Pulse mode, 8-bit then 16-bit compare, counter stopped
        wr(cca_pkg::IDX_CMP_LO, 8'h80, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CMP_HI, 8'hff, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_MODE, 8'h02, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CNT_LO, 8'h7f, cca_pkg::RESP_OKAY);
        `CHK(pin, 1'b0)
        wr(cca_pkg::IDX_CNT_LO, 8'h90, cca_pkg::RESP_OKAY);
        `CHK(pin, 1'b1)
        wr(cca_pkg::IDX_MODE, 8'h82, cca_pkg::RESP_OKAY);
        repeat (3) @(posedge mclk);
        `CHK(pin, 1'b0)
        wr(cca_pkg::IDX_CNT_HI, 8'hff, cca_pkg::RESP_OKAY);
        `CHK(pin, 1'b1)
        $display("test pulse modes done");

        // Frequency output: half period is the compare high byte
        wr(cca_pkg::IDX_MODE, 8'h00, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CNT_LO, 8'h00, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CNT_HI, 8'h00, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CMP_LO, 8'h10, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CMP_HI, 8'h20, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_MODE, 8'h0f, cca_pkg::RESP_OKAY);
        wr(cca_pkg::IDX_CTRL, 8'h40, cca_pkg::RESP_OKAY);
        pin_gap(gap);
        `CHK(gap, 32)
        pin_gap(gap);
        `CHK(gap, 32)
        `CHK(irq, 1'b1)
        wr(cca_pkg::IDX_CTRL, 8'h00, cca_pkg::RESP_OKAY);
        $display("test frequency output done");
        conclude();
    end
endmodule
`undef CHK
`default_nettype wire
